// ---- design/eirwc_params.svh ----
// timing counts, field values and reset values of the eeprom bus front end
// assumes: a 25 MHz core clock and a free-running link sampling clock
// Contract
// - stop under low supply cancels pending write
// - start then stop returns bus logic idle
// - master reset alone leaves device position unchanged unless the device is pulling sda low when it begins
// - device releases sda when master holds high
// - bus ignored until power-up init completes
// - short glitches on scl and sda rejected
// - write only after full byte, stop after ack
// - start mid-command cancels and restarts decode
// - straps default low, sda only pulls low
// - bus ignored, no ack during write cycle
// - address-only write loads pointer, no write
`ifndef EIRWC_PARAMS_SVH
`define EIRWC_PARAMS_SVH

// device type code in the upper address bits
`define EIRWC_DEV_TYPE       4'hA
`define EIRWC_PAGE_BYTES     7'h40
`define EIRWC_PTR_RESET      15'h0000
`define EIRWC_CLK_PERIOD_NS  40
`define EIRWC_LINK_PERIOD_NS 32
`define EIRWC_GLITCH_NS      90
// a 90 ns pulse can cover floor(90/32)+1 samples, so one more is needed to pass
`define EIRWC_GLITCH_CYC     (`EIRWC_GLITCH_NS / `EIRWC_LINK_PERIOD_NS + 2)
`define EIRWC_INIT_CYC       2500
`define EIRWC_WRITE_CYC      2500

`endif

// ---- design/eirwc_pkg.sv ----
// types shared by the eeprom bus front end
// assumes: nothing beyond a SystemVerilog tool
package eirwc_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACKW, ST_ACK, ST_SEND, ST_MACK, ST_HOLD}
    eirwc_state_t;

  typedef enum logic [1:0] {K_DEV, K_AHI, K_ALO, K_DATA} eirwc_kind_t;

endpackage : eirwc_pkg

// ---- design/eirwc_filter.sv ----
// two-flop synchroniser and per-bit stability filter for bus pins
// assumes: clk runs free; rstn is synchronous to clk
`timescale 1ns/100ps
module eirwc_filter
#(
  parameter int               WIDTH  = 2,
  parameter int               STABLE = 4,
  parameter logic [WIDTH-1:0] INIT   = '1
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // raw pins and clean levels
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);
  localparam int CW = $clog2(STABLE + 1);

  logic [WIDTH-1:0] metaReg;
  logic [WIDTH-1:0] syncReg;
  logic [WIDTH-1:0] levelReg;
  logic [WIDTH-1:0] levelNext;
  logic [CW-1:0]    cntReg  [WIDTH];
  logic [CW-1:0]    cntNext [WIDTH];

  if (STABLE < 1 || WIDTH < 1)
  begin : badParam
    $error("eirwc_filter needs STABLE and WIDTH of at least one");
  end

  always_ff @(posedge clk)
  begin
    metaReg <= pinIn;
    syncReg <= metaReg;
  end

  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      levelNext[i] = levelReg[i];
      cntNext[i]   = cntReg[i];
      if (syncReg[i] == levelReg[i])
        cntNext[i] = '0;
      else if (cntReg[i] == CW'(STABLE - 1))
      begin
        levelNext[i] = syncReg[i];
        cntNext[i]   = '0;
      end
      else
        cntNext[i] = cntReg[i] + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      levelReg <= INIT;
      for (int i = 0; i < WIDTH; i++)
        cntReg[i] <= '0;
    end
    else
    begin
      levelReg <= levelNext;
      for (int i = 0; i < WIDTH; i++)
        cntReg[i] <= cntNext[i];
    end
  end

  assign levelOut = levelReg;

  glitch_filter_a: assert property (
    @(posedge clk) disable iff (!rstn)
    $changed(levelReg[0]) |-> $past(syncReg[0], STABLE) == levelReg[0])
    else $error("filtered level changed before the input stayed stable");

endmodule : eirwc_filter

// ---- design/eirwc_top.sv ----
// eeprom two-wire slave front end: bus decode on the link clock, write commit on clk
// assumes: linkClk runs free as the pin sampling clock; memory array lives outside
`timescale 1ns/100ps
`include "eirwc_params.svh"
module eirwc_top
#(
  parameter int INIT_CYCLES  = `EIRWC_INIT_CYC,
  parameter int WRITE_CYCLES = `EIRWC_WRITE_CYC
)
(
  // core clock and power-on clear
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        supplyLow,
  // link sampling clock
  input  wire logic        linkClk,
  // bus and strap pins
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        writeInhibit,
  input  wire logic        chip_select_bit0,
  input  wire logic        chip_select_bit1,
  input  wire logic        chip_select_bit2,
  // link-side data toward the array
  output logic             rxValid,
  output logic [7:0]       rxByte,
  output logic [14:0]      rxAddr,
  output logic [14:0]      addrPointer,
  output logic             readAdvance,
  input  wire logic [7:0]  readData,
  // core-side write cycle
  output logic             initDone,
  output logic             writeStart,
  output logic             writeCancel,
  output logic             writeBusy,
  output logic [14:0]      writeAddr,
  output logic [6:0]       writeCount
);
  localparam int IW = $clog2(INIT_CYCLES + 1);
  localparam int WW = $clog2(WRITE_CYCLES + 1);

  if (INIT_CYCLES < 1 || WRITE_CYCLES < 8)
  begin : badParam
    $error("eirwc_top needs INIT_CYCLES >= 1 and WRITE_CYCLES >= 8");
  end

  // ---------------- link domain ----------------
  logic linkRstMeta, linkRstn, initMeta, initSync, ackMeta, ackSync;
  logic sclF, sdaF, wpF;
  logic ackTglReg, ackTglNext;
  logic [2:0] csF;
  logic [1:0] busLevel;
  logic [3:0] strapLevel;

  always_ff @(posedge linkClk)
  begin
    linkRstMeta <= resetn;
    linkRstn    <= linkRstMeta;
    initMeta    <= initDone;
    initSync    <= initMeta;
    ackMeta     <= ackTglReg;
    ackSync     <= ackMeta;
  end

  eirwc_filter #(.WIDTH(2), .STABLE(`EIRWC_GLITCH_CYC), .INIT(2'b11)) busFilter (
    .clk(linkClk), .rstn(linkRstn), .pinIn({sclIn, sdaIn}), .levelOut(busLevel));
  eirwc_filter #(.WIDTH(4), .STABLE(1), .INIT(4'h0)) strapFilter (
    .clk(linkClk), .rstn(linkRstn),
    .pinIn({writeInhibit, chip_select_bit2, chip_select_bit1, chip_select_bit0}),
    .levelOut(strapLevel));
  assign {sclF, sdaF} = busLevel;
  assign {wpF, csF}   = strapLevel;

  eirwc_pkg::eirwc_state_t stateReg, stateNext;
  eirwc_pkg::eirwc_kind_t  kindReg, kindNext;
  logic [2:0]  bitCntReg, bitCntNext;
  logic [7:0]  shiftReg, shiftNext, rxByteReg, rxByteNext;
  logic [14:0] ptrReg, ptrNext, rxAddrReg, rxAddrNext, commitAddrReg, commitAddrNext;
  logic [6:0]  dataCountReg, dataCountNext, commitCountReg, commitCountNext;
  logic        sdaOeReg, sdaOeNext, isReadReg, isReadNext, masterAckReg, masterAckNext;
  logic        commitTglReg, commitTglNext, rxValidReg, rxValidNext;
  logic        readAdvReg, readAdvNext, sclPrevReg, sdaPrevReg, sdaOutReg;
  logic        sclRise, sclFall, startEv, stopEv, busyLink, linkReady, commitOk, commitGo;
  logic [7:0]  inByte;

  assign sclRise   = sclF & ~sclPrevReg;
  assign sclFall   = ~sclF & sclPrevReg;
  assign startEv   = sclF & sclPrevReg & sdaPrevReg & ~sdaF;
  assign stopEv    = sclF & sclPrevReg & ~sdaPrevReg & sdaF;
  // a commit is outstanding until the core toggles its answer back
  assign busyLink  = commitTglReg ^ ackSync;
  assign linkReady = initSync & ~busyLink;
  assign inByte    = {shiftReg[6:0], sdaF};
  // the stop's own scl rise has already shifted one (low) bit
  assign commitOk  = (stateReg == eirwc_pkg::ST_RECV) && (kindReg == eirwc_pkg::K_DATA) &&
                     (bitCntReg <= 3'h1) && (dataCountReg != 7'h00);
  assign commitGo  = linkReady & stopEv & commitOk;

  always_comb
  begin
    stateNext = stateReg; kindNext = kindReg; bitCntNext = bitCntReg; shiftNext = shiftReg;
    ptrNext = ptrReg; rxAddrNext = rxAddrReg; rxByteNext = rxByteReg; rxValidNext = 1'b0;
    commitAddrNext = commitAddrReg; commitCountNext = commitCountReg;
    commitTglNext = commitTglReg; dataCountNext = dataCountReg; sdaOeNext = sdaOeReg;
    isReadNext = isReadReg; masterAckNext = masterAckReg; readAdvNext = 1'b0;
    if (!linkReady)
    begin
      stateNext = eirwc_pkg::ST_IDLE;
      sdaOeNext = 1'b0;
    end
    else if (startEv)
    begin
      stateNext = eirwc_pkg::ST_RECV; kindNext = eirwc_pkg::K_DEV;
      bitCntNext = 3'h0; dataCountNext = 7'h00; sdaOeNext = 1'b0;
    end
    else if (stopEv)
    begin
      if (commitOk)
      begin
        commitTglNext   = ~commitTglReg;
        commitCountNext = dataCountReg;
      end
      stateNext = eirwc_pkg::ST_IDLE;
      sdaOeNext = 1'b0;
    end
    else
    begin
      unique case (stateReg)
        eirwc_pkg::ST_IDLE, eirwc_pkg::ST_HOLD:
          stateNext = stateReg;
        eirwc_pkg::ST_RECV:
          if (sclRise)
          begin
            shiftNext  = inByte;
            bitCntNext = bitCntReg + 3'h1;
            if (bitCntReg == 3'h7)
            begin
              stateNext = eirwc_pkg::ST_ACKW;
              unique case (kindReg)
                eirwc_pkg::K_DEV:
                begin
                  isReadNext = inByte[0];
                  if (inByte[7:1] != {`EIRWC_DEV_TYPE, csF})
                    stateNext = eirwc_pkg::ST_HOLD;
                end
                eirwc_pkg::K_AHI:
                  ptrNext[14:8] = inByte[6:0];
                eirwc_pkg::K_ALO:
                begin
                  ptrNext[7:0]   = inByte;
                  commitAddrNext = {ptrReg[14:8], inByte};
                end
                eirwc_pkg::K_DATA:
                  // inhibited data gets no ack, so a later stop cannot commit
                  if (wpF)
                    stateNext = eirwc_pkg::ST_HOLD;
                  else
                  begin
                    rxValidNext = 1'b1;
                    rxByteNext  = inByte;
                    rxAddrNext  = ptrReg;
                    ptrNext     = {ptrReg[14:6], ptrReg[5:0] + 6'h01};
                    if (dataCountReg != `EIRWC_PAGE_BYTES)
                      dataCountNext = dataCountReg + 7'h01;
                  end
              endcase
            end
          end
        eirwc_pkg::ST_ACKW:
          if (sclFall)
          begin
            sdaOeNext = 1'b1;
            stateNext = eirwc_pkg::ST_ACK;
          end
        eirwc_pkg::ST_ACK:
          if (sclFall)
          begin
            bitCntNext = 3'h0;
            if (kindReg == eirwc_pkg::K_DEV && isReadReg)
            begin
              shiftNext = readData;
              sdaOeNext = ~readData[7];
              stateNext = eirwc_pkg::ST_SEND;
            end
            else
            begin
              sdaOeNext = 1'b0;
              stateNext = eirwc_pkg::ST_RECV;
              unique case (kindReg)
                eirwc_pkg::K_DEV: kindNext = eirwc_pkg::K_AHI;
                eirwc_pkg::K_AHI: kindNext = eirwc_pkg::K_ALO;
                eirwc_pkg::K_ALO, eirwc_pkg::K_DATA: kindNext = eirwc_pkg::K_DATA;
              endcase
            end
          end
        eirwc_pkg::ST_SEND:
          if (sclFall)
          begin
            if (bitCntReg == 3'h7)
            begin
              sdaOeNext   = 1'b0;
              stateNext   = eirwc_pkg::ST_MACK;
              ptrNext     = ptrReg + 15'h0001;
              readAdvNext = 1'b1;
            end
            else
            begin
              bitCntNext = bitCntReg + 3'h1;
              shiftNext  = {shiftReg[6:0], 1'b0};
              sdaOeNext  = ~shiftReg[6];
            end
          end
        eirwc_pkg::ST_MACK:
          if (sclRise)
            masterAckNext = ~sdaF;
          else if (sclFall)
          begin
            if (masterAckReg)
            begin
              shiftNext  = readData;
              sdaOeNext  = ~readData[7];
              bitCntNext = 3'h0;
              stateNext  = eirwc_pkg::ST_SEND;
            end
            else
              stateNext = eirwc_pkg::ST_HOLD;
          end
      endcase
    end
  end

  always_ff @(posedge linkClk)
  begin
    if (!linkRstn)
    begin
      stateReg <= eirwc_pkg::ST_IDLE; kindReg <= eirwc_pkg::K_DEV; bitCntReg <= 3'h0;
      shiftReg <= 8'h00; ptrReg <= `EIRWC_PTR_RESET; rxAddrReg <= 15'h0000;
      rxByteReg <= 8'h00; rxValidReg <= 1'b0; commitAddrReg <= 15'h0000;
      commitCountReg <= 7'h00; commitTglReg <= 1'b0; dataCountReg <= 7'h00;
      sdaOeReg <= 1'b0; isReadReg <= 1'b0; masterAckReg <= 1'b0; readAdvReg <= 1'b0;
      sclPrevReg <= 1'b1; sdaPrevReg <= 1'b1; sdaOutReg <= 1'b0;
    end
    else
    begin
      stateReg <= stateNext; kindReg <= kindNext; bitCntReg <= bitCntNext;
      shiftReg <= shiftNext; ptrReg <= ptrNext; rxAddrReg <= rxAddrNext;
      rxByteReg <= rxByteNext; rxValidReg <= rxValidNext; commitAddrReg <= commitAddrNext;
      commitCountReg <= commitCountNext; commitTglReg <= commitTglNext;
      dataCountReg <= dataCountNext; sdaOeReg <= sdaOeNext; isReadReg <= isReadNext;
      masterAckReg <= masterAckNext; readAdvReg <= readAdvNext;
      sclPrevReg <= sclF; sdaPrevReg <= sdaF; sdaOutReg <= 1'b0;
    end
  end

  assign sdaOut = sdaOutReg;
  assign sdaOe = sdaOeReg;
  assign rxValid = rxValidReg;
  assign rxByte = rxByteReg;
  assign rxAddr = rxAddrReg;
  assign addrPointer = ptrReg;
  assign readAdvance = readAdvReg;

  // ---------------- core domain ----------------
  logic          cmtMeta, cmtSync, lowMeta, lowSync, commitEdge;
  logic          commitSeenReg, commitSeenNext;
  logic          initDoneReg, initDoneNext, busyReg, busyNext;
  logic          startReg, startNext, cancelReg, cancelNext;
  logic [IW-1:0] initCntReg, initCntNext;
  logic [WW-1:0] wrCntReg, wrCntNext;
  logic [14:0]   wAddrReg, wAddrNext;
  logic [6:0]    wCountReg, wCountNext;

  always_ff @(posedge clk)
  begin
    cmtMeta <= commitTglReg;
    cmtSync <= cmtMeta;
    lowMeta <= supplyLow;
    lowSync <= lowMeta;
  end

  // address and count are held still by the link while a commit is outstanding
  assign commitEdge = cmtSync ^ commitSeenReg;

  always_comb
  begin
    initCntNext = initCntReg; initDoneNext = initDoneReg; commitSeenNext = commitSeenReg;
    ackTglNext = ackTglReg; busyNext = busyReg; wrCntNext = wrCntReg;
    wAddrNext = wAddrReg; wCountNext = wCountReg; startNext = 1'b0; cancelNext = 1'b0;
    if (!initDoneReg)
    begin
      if (initCntReg == IW'(INIT_CYCLES - 1))
        initDoneNext = 1'b1;
      else
        initCntNext = initCntReg + 1'b1;
    end
    if (commitEdge)
    begin
      commitSeenNext = cmtSync;
      if (lowSync)
      begin
        cancelNext = 1'b1;
        ackTglNext = cmtSync;
      end
      else
      begin
        startNext  = 1'b1;
        busyNext   = 1'b1;
        wrCntNext  = '0;
        wAddrNext  = commitAddrReg;
        wCountNext = commitCountReg;
      end
    end
    else if (busyReg)
    begin
      if (wrCntReg == WW'(WRITE_CYCLES - 1))
      begin
        busyNext   = 1'b0;
        ackTglNext = commitSeenReg;
      end
      else
        wrCntNext = wrCntReg + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      initCntReg <= '0; initDoneReg <= 1'b0; commitSeenReg <= 1'b0; ackTglReg <= 1'b0;
      busyReg <= 1'b0; wrCntReg <= '0; wAddrReg <= 15'h0000; wCountReg <= 7'h00;
      startReg <= 1'b0; cancelReg <= 1'b0;
    end
    else
    begin
      initCntReg <= initCntNext; initDoneReg <= initDoneNext;
      commitSeenReg <= commitSeenNext; ackTglReg <= ackTglNext; busyReg <= busyNext;
      wrCntReg <= wrCntNext; wAddrReg <= wAddrNext; wCountReg <= wCountNext;
      startReg <= startNext; cancelReg <= cancelNext;
    end
  end

  assign initDone = initDoneReg;
  assign writeStart = startReg;
  assign writeCancel = cancelReg;
  assign writeBusy = busyReg;
  assign writeAddr = wAddrReg;
  assign writeCount = wCountReg;

  // ---------------- checks ----------------
  sequence wrBegin;
    commitEdge && !lowSync;
  endsequence
  sequence nackFall;
    linkReady && !startEv && !stopEv && stateReg == eirwc_pkg::ST_MACK && sclFall &&
    !masterAckReg;
  endsequence

  low_cancel_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (commitEdge && lowSync) |=> cancelReg && !startReg && !busyReg)
    else $error("write not cancelled under low supply");
  write_hold_a: assert property (
    @(posedge clk) disable iff (!resetn)
    wrBegin |=> startReg ##1 (busyReg && !startReg)[*6])
    else $error("write cycle did not hold busy");
  init_lock_a: assert property (
    @(posedge linkClk) disable iff (!linkRstn)
    !initSync |=> stateReg == eirwc_pkg::ST_IDLE && !sdaOeReg)
    else $error("bus decoded during init");
  busy_deaf_a: assert property (
    @(posedge linkClk) disable iff (!linkRstn)
    busyLink |=> !sdaOeReg && stateReg == eirwc_pkg::ST_IDLE)
    else $error("sda driven during write cycle");
  start_new_a: assert property (
    @(posedge linkClk) disable iff (!linkRstn)
    (linkReady && startEv) |=> stateReg == eirwc_pkg::ST_RECV &&
      kindReg == eirwc_pkg::K_DEV && bitCntReg == 3'h0)
    else $error("start did not restart decode");
  stop_idle_a: assert property (
    @(posedge linkClk) disable iff (!linkRstn)
    (linkReady && stopEv) |=> stateReg == eirwc_pkg::ST_IDLE && !sdaOeReg)
    else $error("stop did not return to idle");
  commit_gate_a: assert property (
    @(posedge linkClk) disable iff (!linkRstn)
    $changed(commitTglReg) |-> $past(commitGo))
    else $error("write committed without stop after ack");
  nack_release_a: assert property (
    @(posedge linkClk) disable iff (!linkRstn)
    nackFall |=> stateReg == eirwc_pkg::ST_HOLD && !sdaOeReg)
    else $error("sda not released after master high");
  hold_still_a: assert property (
    @(posedge linkClk) disable iff (!linkRstn)
    (stateReg == eirwc_pkg::ST_HOLD && linkReady && !startEv && !stopEv)
      |=> stateReg == eirwc_pkg::ST_HOLD)
    else $error("hold left without start or stop");

endmodule : eirwc_top

// ---- test/eirwc_master.sv ----
// bus master model: drives scl and its own share of sda
// assumes: the bench resolves sda as open drain with a pull-up
`timescale 1ns/100ps
module eirwc_master
(
  // bus pins
  output logic      scl,
  output logic      sdaDrv,
  input  wire logic sdaLine,
  // short pulses on scl in each bit, and on sda in each bit driven high
  input  wire logic glitch
);
  initial
  begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic bus_start();
    sdaDrv = 1'b1;
    #300 scl = 1'b1;
    #150 sdaDrv = 1'b0;
    #150 scl = 1'b0;
  endtask : bus_start

  task automatic bus_stop();
    sdaDrv = 1'b0;
    #300 scl = 1'b1;
    #150 sdaDrv = 1'b1;
  endtask : bus_stop

  // low phase long enough for the filtered fall and the device's answer
  // glitches are 80 ns, under the filter limit
  task automatic put_bit(input logic b, output logic s);
    sdaDrv = b;
    #150 scl = glitch;
    #80 scl = 1'b0;
    #150 scl = 1'b1;
    #100 sdaDrv = b & ~glitch;
    #80 sdaDrv = b;
    #70 s = sdaLine;
    #50 scl = 1'b0;
  endtask : put_bit

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte

  task automatic read_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(1'b1, d[i]);
    put_bit(~mack, s);
  endtask : read_byte

  task automatic recover();
    logic s;
    bus_start();
    repeat (9)
      put_bit(1'b1, s);
    bus_start();
    bus_stop();
  endtask : recover

  task automatic open_bus();
    if (sdaLine !== 1'b1)
      recover();
    bus_start();
  endtask : open_bus
endmodule : eirwc_master

// ---- test/eirwc_top_test.sv ----
// self-checking bench for the eeprom bus front end
// assumes: master model on the bus, pull-up on sda, straps left open (low)
`timescale 1ns/100ps
`include "eirwc_params.svh"
module eirwc_top_test;
  localparam int         INIT = 40;
  localparam int         WCYC = 200;
  localparam logic [7:0] DEVW = {`EIRWC_DEV_TYPE, 4'h0};
  localparam logic [7:0] DEVR = {`EIRWC_DEV_TYPE, 4'h1};
  logic        clk = 1'b0, linkClk = 1'b0, resetn = 1'b0, supplyLow = 1'b0;
  logic        writeInhibit = 1'b0, glitch = 1'b0, scl, sdaDrv, sdaIn;
  logic        sdaOut, sdaOe, rxValid, readAdvance, initDone;
  logic        writeStart, writeCancel, writeBusy;
  logic [7:0]  rxByte, readData, lastRx;
  logic [14:0] rxAddr, addrPointer, writeAddr, wAddr, lastRxAddr;
  logic [6:0]  writeCount, wCnt;
  int          fails = 0, checks = 0, starts = 0, cancels = 0, advs = 0;

  always #20 clk = ~clk;
  always #16 linkClk = ~linkClk;
  // memory stand-in: byte value follows the pointer
  assign readData = addrPointer[7:0] ^ 8'h3C;
  assign sdaIn = sdaDrv & (~sdaOe | sdaOut);

  eirwc_top #(.INIT_CYCLES(INIT), .WRITE_CYCLES(WCYC)) i_dut
  (
    .clk(clk), .resetn(resetn), .supplyLow(supplyLow), .linkClk(linkClk),
    .sclIn(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .writeInhibit(writeInhibit), .chip_select_bit0(1'b0),
    .chip_select_bit1(1'b0), .chip_select_bit2(1'b0),
    .rxValid(rxValid), .rxByte(rxByte), .rxAddr(rxAddr),
    .addrPointer(addrPointer), .readAdvance(readAdvance), .readData(readData),
    .initDone(initDone), .writeStart(writeStart), .writeCancel(writeCancel),
    .writeBusy(writeBusy), .writeAddr(writeAddr), .writeCount(writeCount)
  );
  eirwc_master i_master (.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaIn), .glitch(glitch));

  task automatic chk_bit(input string what, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit

  task automatic chk_val(input string what, input logic [14:0] e, input logic [14:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk_val

  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  always @(posedge clk)
    if (writeStart === 1'b1)
    begin
      starts <= starts + 1;
      wAddr <= writeAddr;
      wCnt <= writeCount;
    end
  always @(posedge clk)
    if (writeCancel === 1'b1)
      cancels <= cancels + 1;
  always @(posedge linkClk)
    if (rxValid === 1'b1)
    begin
      lastRx <= rxByte;
      lastRxAddr <= rxAddr;
    end
  always @(posedge linkClk)
    if (readAdvance === 1'b1)
      advs <= advs + 1;
  always @(negedge linkClk)
    if (sdaOe === 1'b1)
      chk_bit("sdaOut", 1'b0, sdaOut);

  task automatic wait_busy(input logic lvl);
    int n = 0;
    while (writeBusy !== lvl && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 2000)
    begin
      chk_bit("writeBusy", lvl, writeBusy);
      final_report();
    end
  endtask : wait_busy

  task automatic xfer(input logic [7:0] d, input logic expAck);
    logic a;
    i_master.send_byte(d, a);
    chk_bit("ack", expAck, a);
  endtask : xfer

  task automatic t_init();
    logic a;
    int   n = 0;
    fork
      begin
        i_master.bus_start();
        i_master.send_byte(DEVW, a);
        i_master.bus_stop();
      end
      while (initDone !== 1'b1 && n < 100)
      begin
        @(negedge clk);
        n++;
      end
    join
    chk_bit("ack in init", 1'b0, a);
    chk_bit("init interval", 1'b1, n >= INIT && n <= INIT + 2);
  endtask : t_init

  task automatic t_write();
    int s0 = starts;
    i_master.open_bus();
    xfer(DEVW, 1'b1);
    xfer(8'h01, 1'b1);
    xfer(8'h3E, 1'b1);
    glitch = 1'b1;
    xfer(8'h5A, 1'b1);
    xfer(8'hC3, 1'b1);
    xfer(8'hFF, 1'b1);
    glitch = 1'b0;
    i_master.bus_stop();
    wait_busy(1'b1);
    repeat (2)
      @(negedge clk);
    chk_val("writes", 15'(s0 + 1), 15'(starts));
    chk_val("writeAddr", 15'h013E, wAddr);
    chk_val("writeCount", 15'h0003, {8'h00, wCnt});
    chk_val("rxByte", 15'h00FF, {7'h00, lastRx});
    chk_val("rxAddr", 15'h0100, lastRxAddr);
    i_master.bus_start();
    xfer(DEVW, 1'b0);
    i_master.bus_stop();
    wait_busy(1'b0);
    i_master.bus_start();
    xfer(DEVW, 1'b1);
    i_master.bus_stop();
  endtask : t_write

  task automatic t_dummy();
    logic s;
    int   s0 = starts;
    i_master.open_bus();
    xfer(DEVW, 1'b1);
    xfer(8'h01, 1'b1);
    xfer(8'h23, 1'b1);
    i_master.bus_stop();
    chk_val("pointer", 15'h0123, addrPointer);
    i_master.open_bus();
    xfer(DEVW, 1'b1);
    xfer(8'h02, 1'b1);
    xfer(8'h00, 1'b1);
    repeat (4)
      i_master.put_bit(1'b0, s);
    i_master.bus_stop();
    repeat (100)
      @(negedge clk);
    chk_val("writes", 15'(s0), 15'(starts));
  endtask : t_dummy

  task automatic t_read();
    logic [7:0] d;
    int         a0 = advs;
    i_master.open_bus();
    xfer(DEVW, 1'b1);
    xfer(8'h01, 1'b1);
    xfer(8'h23, 1'b1);
    i_master.bus_start();
    xfer(DEVR, 1'b1);
    i_master.read_byte(1'b0, d);
    i_master.bus_stop();
    chk_val("read data", 15'h001F, {7'h00, d});
    chk_val("pointer", 15'h0124, addrPointer);
    chk_val("readAdvance", 15'(a0 + 1), 15'(advs));
  endtask : t_read

  task automatic t_lowsup();
    int s0 = starts;
    int c0 = cancels;
    @(posedge clk);
    supplyLow <= 1'b1;
    i_master.open_bus();
    xfer(DEVW, 1'b1);
    xfer(8'h00, 1'b1);
    xfer(8'h10, 1'b1);
    xfer(8'h77, 1'b1);
    i_master.bus_stop();
    repeat (100)
      @(negedge clk);
    chk_val("cancels", 15'(c0 + 1), 15'(cancels));
    chk_val("writes", 15'(s0), 15'(starts));
    chk_bit("writeBusy", 1'b0, writeBusy);
    @(posedge clk);
    supplyLow <= 1'b0;
  endtask : t_lowsup

  task automatic t_cancel();
    logic s;
    i_master.open_bus();
    xfer(DEVW, 1'b1);
    xfer(8'h02, 1'b1);
    repeat (3)
      i_master.put_bit(1'b1, s);
    i_master.bus_start();
    xfer(DEVW, 1'b1);
    xfer(8'h00, 1'b1);
    xfer(8'h40, 1'b1);
    i_master.bus_stop();
    chk_val("pointer", 15'h0040, addrPointer);
  endtask : t_cancel

  // device left driving a zero read bit while the master goes quiet
  task automatic t_recover();
    i_master.open_bus();
    xfer(DEVR, 1'b1);
    #3000;
    chk_bit("held sda", 1'b1, sdaOe);
    i_master.open_bus();
    chk_bit("released sda", 1'b0, sdaOe);
    xfer(DEVW, 1'b1);
    i_master.bus_stop();
  endtask : t_recover

  initial
  begin
    repeat (10)
      @(posedge clk);
    resetn <= 1'b1;
    t_init();
    i_master.recover();
    t_write();
    t_dummy();
    t_read();
    t_lowsup();
    t_cancel();
    t_recover();
    final_report();
  end
endmodule : eirwc_top_test
